// ==== rtl/expander_pkg.sv ====
// Register map, field positions and reset values of the expander control block
package expander_pkg;
    localparam int         PORT_COUNT       = 8;
    localparam int         NIBBLE_WIDTH     = 4;
    // Register addresses
    localparam logic [7:0] ADDR_INPUT_PORTS = 8'h00;
    localparam logic [7:0] ADDR_PHASE0      = 8'h01;
    localparam logic [7:0] ADDR_DIRECTION   = 8'h03;
    localparam logic [7:0] ADDR_PHASE1      = 8'h09;
    localparam logic [7:0] ADDR_MASTER      = 8'h0E;
    localparam logic [7:0] ADDR_CONFIG      = 8'h0F;
    localparam logic [7:0] ADDR_INTENS_0    = 8'h10;
    localparam logic [7:0] ADDR_INTENS_1    = 8'h11;
    localparam logic [7:0] ADDR_INTENS_2    = 8'h12;
    localparam logic [7:0] ADDR_INTENS_3    = 8'h13;
    // Configuration register fields
    localparam int         CFG_PHASE_EN     = 0;
    localparam int         CFG_FLIP         = 1;
    localparam int         CFG_GLOBAL       = 2;
    localparam int         CFG_IRQ_EN       = 3;
    localparam int         CFG_PIN9_PHASE0  = 4;
    localparam int         CFG_PIN9_PHASE1  = 5;
    localparam int         CFG_ZERO_BIT     = 6;
    localparam int         CFG_IRQ_STATUS   = 7;
    localparam logic [7:0] CFG_STORED_MASK  = 8'h3F;
    // Power-up values
    localparam logic [7:0] RESET_PHASE0     = 8'hFF;
    localparam logic [7:0] RESET_DIRECTION  = 8'hFF;
    localparam logic [7:0] RESET_PHASE1     = 8'hFF;
    localparam logic [7:0] RESET_MASTER     = 8'h0F;
    localparam logic [7:0] RESET_CONFIG     = 8'h0C;
    localparam logic [7:0] RESET_INTENSITY  = 8'hFF;
    localparam logic [7:0] READ_UNMAPPED    = 8'h00;
endpackage : expander_pkg

// ==== rtl/expander_input_sync.sv ====
// Three-stage pin synchroniser that updates only when stages two and three agree
`timescale 1ns/100ps
`default_nettype none
module expander_input_sync
    import expander_pkg::*;
(
    input  wire logic                  i_clock,  // System clock
    input  wire logic                  i_reset,  // Async reset, active high
    input  wire logic [PORT_COUNT-1:0] i_async,  // Raw port levels
    output logic      [PORT_COUNT-1:0] o_stable  // Debounced levels
);
    genvar g;
    generate
        for (g = 0; g < PORT_COUNT; g++) begin : g_bit
            logic s1_q, s2_q, s3_q, stable_q;
            logic s1_d, s2_d, s3_d, stable_d;
            always_comb begin
                s1_d     = i_async[g];
                s2_d     = s1_q;
                s3_d     = s2_q;
                // Single-cycle glitches reach the compare but never get past it
                stable_d = (s2_q == s3_q) ? s3_q : stable_q;
            end
            always_ff @(posedge i_clock or posedge i_reset) begin
                if (i_reset) begin
                    s1_q     <= 1'b1;
                    s2_q     <= 1'b1;
                    s3_q     <= 1'b1;
                    stable_q <= 1'b1;
                end else begin
                    s1_q     <= s1_d;
                    s2_q     <= s2_d;
                    s3_q     <= s3_d;
                    stable_q <= stable_d;
                end
            end
            assign o_stable[g] = stable_q;
        end
    endgenerate
endmodule : expander_input_sync
`default_nettype wire

// ==== rtl/expander_config_blink_ctrl.sv ====
// Configuration, phase pattern, direction and change detection of the I/O expander
`timescale 1ns/100ps
`default_nettype none
// Function
// - Config D0 enables phase alternation
// - Flip bit picks phase 0 or 1
// - Alternation off uses phase 0 only
// - Global bit: master low nibble intensity
// - Otherwise per-port nibbles, ninth upper nibble
// - Irq enable: ninth pin shows change flag
// - No irq, no alternation: D4 drives pin
// - No irq, alternation: D4/D5 by phase
// - D7 reads live change status
// - D6 ignores writes, reads zero
// - Pattern one floats, zero drives low
// - Only output ports are driven
// - Direction register, one means input, readable
// - Config readback: stored bits plus status
// - Config write resamples change reference
// - Mismatch flags; returns or input read clear
// - Power-up: inputs, alternation off
module expander_config_blink_ctrl
    import expander_pkg::*;
(
    input  wire logic                    i_clock,            // 250 MHz system clock
    input  wire logic                    i_reset,            // Async reset, active high
    input  wire logic                    i_wr_en,            // Byte write strobe
    input  wire logic                    i_rd_en,            // Byte read strobe
    input  wire logic [7:0]              i_addr,             // Register address
    input  wire logic [7:0]              i_wdata,            // Write byte
    output logic      [7:0]              o_rdata,            // Read byte
    output logic                         o_rvalid,           // Read byte valid pulse
    input  wire logic [PORT_COUNT-1:0]   i_port_level,       // Port pin levels
    output logic      [PORT_COUNT-1:0]   o_port_out,         // Port output value
    output logic      [PORT_COUNT-1:0]   o_port_oe,          // Port drive-low enable
    output logic                         o_ninth_output_out, // Ninth pin output value
    output logic                         o_ninth_output_oe,  // Ninth pin drive-low enable
    output logic      [4*PORT_COUNT-1:0] o_port_intensity,   // Per-port intensity nibbles
    output logic      [3:0]              o_ninth_intensity   // Ninth pin intensity
);
    logic [PORT_COUNT-1:0] level_sync;
    expander_input_sync expander_input_sync_i (
        .i_clock  (i_clock),
        .i_reset  (i_reset),
        .i_async  (i_port_level),
        .o_stable (level_sync)
    );

    logic [7:0]  phase0_q, phase0_d, phase1_q, phase1_d, direction_q, direction_d;
    logic [7:0]  master_q, master_d, config_q, config_d, rdata_q, rdata_d;
    logic [31:0] intens_q, intens_d;
    logic [7:0]  reference_q, reference_d, port_oe_q, port_oe_d;
    logic [31:0] port_int_q, port_int_d;
    logic [3:0]  ninth_int_q, ninth_int_d;
    logic        ref_init_q, ref_init_d, rvalid_q, rvalid_d, ninth_oe_q, ninth_oe_d;
    logic        irq_flag, phase_sel;
    logic [7:0]  pattern;

    assign irq_flag  = |((level_sync ^ reference_q) & direction_q);
    assign phase_sel = config_q[CFG_PHASE_EN] & config_q[CFG_FLIP];
    // Phase 1 ignored when alternation off
    assign pattern   = phase_sel ? phase1_q : phase0_q;

    always_comb begin
        phase0_d    = phase0_q;
        phase1_d    = phase1_q;
        direction_d = direction_q;
        master_d    = master_q;
        config_d    = config_q;
        intens_d    = intens_q;
        reference_d = reference_q;
        ref_init_d  = 1'b1;
        rdata_d     = rdata_q;
        rvalid_d    = 1'b0;
        // Reference is caught after reset release, never under reset
        if (!ref_init_q) begin
            reference_d = level_sync;
        end
        if (i_wr_en) begin
            case (i_addr)
                ADDR_PHASE0:    phase0_d = i_wdata;
                ADDR_PHASE1:    phase1_d = i_wdata;
                ADDR_DIRECTION: direction_d = i_wdata;
                ADDR_MASTER:    master_d = i_wdata;
                ADDR_CONFIG: begin
                    config_d    = i_wdata & CFG_STORED_MASK;
                    reference_d = level_sync;
                end
                ADDR_INTENS_0:  intens_d[7:0]   = i_wdata;
                ADDR_INTENS_1:  intens_d[15:8]  = i_wdata;
                ADDR_INTENS_2:  intens_d[23:16] = i_wdata;
                ADDR_INTENS_3:  intens_d[31:24] = i_wdata;
                default:        ;
            endcase
        end
        if (i_rd_en) begin
            rvalid_d = 1'b1;
            case (i_addr)
                ADDR_INPUT_PORTS: begin
                    rdata_d     = level_sync;
                    reference_d = level_sync;
                end
                ADDR_PHASE0:    rdata_d = phase0_q;
                ADDR_PHASE1:    rdata_d = phase1_q;
                ADDR_DIRECTION: rdata_d = direction_q;
                ADDR_MASTER:    rdata_d = master_q;
                ADDR_CONFIG:    rdata_d = {irq_flag, 1'b0, config_q[5:0]};
                ADDR_INTENS_0:  rdata_d = intens_q[7:0];
                ADDR_INTENS_1:  rdata_d = intens_q[15:8];
                ADDR_INTENS_2:  rdata_d = intens_q[23:16];
                ADDR_INTENS_3:  rdata_d = intens_q[31:24];
                default:        rdata_d = READ_UNMAPPED;
            endcase
        end
        // Zero bit drives low; inputs undriven
        port_oe_d = ~pattern & ~direction_q;
        port_int_d  = config_q[CFG_GLOBAL] ? {PORT_COUNT{master_q[3:0]}} : intens_q;
        ninth_int_d = config_q[CFG_GLOBAL] ? master_q[3:0] : master_q[7:4];
        if (config_q[CFG_IRQ_EN]) begin
            ninth_oe_d = irq_flag;
        end else if (!config_q[CFG_PHASE_EN]) begin
            ninth_oe_d = ~config_q[CFG_PIN9_PHASE0];
        end else begin
            ninth_oe_d = config_q[CFG_FLIP] ? ~config_q[CFG_PIN9_PHASE1] : ~config_q[CFG_PIN9_PHASE0];
        end
    end

    // Power-up state; outputs follow one edge after write
    always_ff @(posedge i_clock or posedge i_reset) begin
        if (i_reset) begin
            phase0_q    <= RESET_PHASE0;
            phase1_q    <= RESET_PHASE1;
            direction_q <= RESET_DIRECTION;
            master_q    <= RESET_MASTER;
            config_q    <= RESET_CONFIG;
            intens_q    <= {4{RESET_INTENSITY}};
            reference_q <= 8'hFF;
            ref_init_q  <= 1'b0;
            rdata_q     <= 8'h00;
            rvalid_q    <= 1'b0;
            port_oe_q   <= 8'h00;
            port_int_q  <= 32'h0000_0000;
            ninth_int_q <= 4'h0;
            ninth_oe_q  <= 1'b0;
        end else begin
            phase0_q    <= phase0_d;
            phase1_q    <= phase1_d;
            direction_q <= direction_d;
            master_q    <= master_d;
            config_q    <= config_d;
            intens_q    <= intens_d;
            reference_q <= reference_d;
            ref_init_q  <= ref_init_d;
            rdata_q     <= rdata_d;
            rvalid_q    <= rvalid_d;
            port_oe_q   <= port_oe_d;
            port_int_q  <= port_int_d;
            ninth_int_q <= ninth_int_d;
            ninth_oe_q  <= ninth_oe_d;
        end
    end

    assign o_rdata            = rdata_q;
    assign o_rvalid           = rvalid_q;
    assign o_port_out         = '0;
    assign o_port_oe          = port_oe_q;
    assign o_ninth_output_out = 1'b0;
    assign o_ninth_output_oe  = ninth_oe_q;
    assign o_port_intensity   = port_int_q;
    assign o_ninth_intensity  = ninth_int_q;

    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_reset);

    sequence cfg_write_s;
        i_wr_en && i_addr == ADDR_CONFIG;
    endsequence
    sequence cfg_read_s;
        i_rd_en && i_addr == ADDR_CONFIG && !i_wr_en;
    endsequence
    sequence input_read_s;
        i_rd_en && i_addr == ADDR_INPUT_PORTS;
    endsequence
    sequence dir_read_s;
        i_rd_en && i_addr == ADDR_DIRECTION;
    endsequence

    phase_enable_a: assert property (cfg_write_s |=> config_q[CFG_PHASE_EN] == $past(i_wdata[0]))
        else $error("phase enable not stored");
    pattern_select_a: assert property (!i_wr_en ##1 !i_wr_en |=>
        o_port_oe == $past(~direction_q & ~((config_q[CFG_PHASE_EN] && config_q[CFG_FLIP]) ? phase1_q : phase0_q)))
        else $error("port pattern mismatch");
    phase0_only_a: assert property (!config_q[CFG_PHASE_EN] && !i_wr_en |=>
        o_port_oe == ($past(~phase0_q) & $past(~direction_q)))
        else $error("phase 1 used while alternation off");
    global_int_a: assert property (config_q[CFG_GLOBAL] |=> o_ninth_intensity == $past(master_q[3:0])
        && o_port_intensity == {PORT_COUNT{$past(master_q[3:0])}})
        else $error("global intensity not applied");
    local_int_a: assert property (!config_q[CFG_GLOBAL] |=> o_port_intensity == $past(intens_q)
        && o_ninth_intensity == $past(master_q[7:4]))
        else $error("per-port intensity not applied");
    ninth_irq_a: assert property (config_q[CFG_IRQ_EN] |=> o_ninth_output_oe == $past(irq_flag))
        else $error("ninth pin not following flag");
    ninth_static_a: assert property (!config_q[CFG_IRQ_EN] && !config_q[CFG_PHASE_EN] |=>
        o_ninth_output_oe == !$past(config_q[CFG_PIN9_PHASE0]))
        else $error("ninth pin static level wrong");
    ninth_blink_a: assert property (!config_q[CFG_IRQ_EN] && config_q[CFG_PHASE_EN] |=>
        o_ninth_output_oe == !$past(config_q[CFG_FLIP] ? config_q[CFG_PIN9_PHASE1] : config_q[CFG_PIN9_PHASE0]))
        else $error("ninth pin phase level wrong");
    dir_read_a: assert property (dir_read_s |=> o_rvalid && o_rdata == $past(direction_q))
        else $error("direction readback wrong");
    status_read_a: assert property (cfg_read_s |=> o_rvalid && o_rdata[6] == 1'b0
        && o_rdata[7] == $past(irq_flag) && o_rdata[5:0] == $past(config_q[5:0]))
        else $error("config readback wrong");
    inputs_undriven_a: assert property ((o_port_oe & $past(direction_q)) == 8'h00)
        else $error("input port driven");
    resample_clear_a: assert property (cfg_write_s ##1 $stable(level_sync) |-> !irq_flag)
        else $error("flag set after resample");
    input_read_a: assert property (input_read_s ##1 $stable(level_sync) |-> !irq_flag)
        else $error("flag set after input read");
endmodule : expander_config_blink_ctrl
`default_nettype wire

// ==== tb/host_model.sv ====
// Host-side register master issuing byte write and read strobes
`timescale 1ns/100ps
`default_nettype none
module host_model (
    input  wire logic       i_clock,        // System clock
    input  wire logic [7:0] i_rdata,        // Read byte
    input  wire logic       i_rvalid,       // Read valid pulse
    output logic            o_wr_en = 1'b0, // Write strobe
    output logic            o_rd_en = 1'b0, // Read strobe
    output logic      [7:0] o_addr = 8'h00, // Address
    output logic      [7:0] o_wdata = 8'h00 // Write byte
);
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge i_clock);
        o_addr = a;
        o_wdata = d;
        o_wr_en = 1'b1;
        @(negedge i_clock);
        o_wr_en = 1'b0;
        // Released lines show garbage, not the last byte
        o_wdata = ~d;
        o_addr = ~a;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge i_clock);
        o_addr = a;
        o_rd_en = 1'b1;
        @(negedge i_clock);
        o_rd_en = 1'b0;
        o_addr = ~a;
        d = (i_rvalid === 1'b1) ? i_rdata : 8'hxx;
    endtask
endmodule // host_model
`default_nettype wire

// ==== tb/expander_config_blink_ctrl_test.sv ====
// Self-checking bench for the expander configuration block
`timescale 1ns/100ps
`default_nettype none
module expander_config_blink_ctrl_test;
    import expander_pkg::*;
    logic        clock = 1'b0;
    logic        reset = 1'b1;
    logic        wr_en, rd_en, rvalid, ninth_out, ninth_oe;
    logic [7:0]  addr, wdata, rdata, port_out, port_oe, rb, c;
    logic [7:0]  level = 8'hFF;
    logic [31:0] intensity;
    logic [3:0]  ninth_int;
    int          mismatches = 0;
    int          tests_run = 0;
    always #2 clock = ~clock;
    expander_config_blink_ctrl expander_config_blink_ctrl_i (.i_clock(clock), .i_reset(reset),
        .i_wr_en(wr_en), .i_rd_en(rd_en), .i_addr(addr), .i_wdata(wdata), .o_rdata(rdata),
        .o_rvalid(rvalid), .i_port_level(level), .o_port_out(port_out), .o_port_oe(port_oe),
        .o_ninth_output_out(ninth_out), .o_ninth_output_oe(ninth_oe),
        .o_port_intensity(intensity), .o_ninth_intensity(ninth_int));
    host_model host_model_i (.i_clock(clock), .i_rdata(rdata), .i_rvalid(rvalid),
        .o_wr_en(wr_en), .o_rd_en(rd_en), .o_addr(addr), .o_wdata(wdata));
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic rchk(input string what, input logic [7:0] a, input logic [7:0] exp);
        host_model_i.rd(a, rb);
        chk(what, 32'(exp), 32'(rb));
    endtask
    task automatic wset(input logic [7:0] a, input logic [7:0] d);
        host_model_i.wr(a, d);
        repeat (2) @(negedge clock);
    endtask
    task automatic t_reset();
        rchk("dir", ADDR_DIRECTION, 8'hFF);
        rchk("cfg", ADDR_CONFIG, 8'h0C);
        chk("oe", 32'h0000_0000, 32'(port_oe));
        chk("int rst", 32'hFFFF_FFFF, intensity);
        chk("nint rst", 32'h0000_000F, 32'(ninth_int));
    endtask
    task automatic t_pattern();
        host_model_i.wr(ADDR_DIRECTION, 8'h00);
        host_model_i.wr(ADDR_PHASE0, 8'hA5);
        host_model_i.wr(ADDR_PHASE1, 8'h3C);
        wset(ADDR_CONFIG, 8'h02);
        chk("oe e0", 32'h0000_005A, 32'(port_oe));
        chk("out", 32'h0000_0000, 32'(port_out));
        host_model_i.wr(ADDR_CONFIG, 8'h03);
        // Write taken one edge ago; pins only move on the next edge
        chk("oe early", 32'h0000_005A, 32'(port_oe));
        @(negedge clock);
        chk("oe b1", 32'h0000_00C3, 32'(port_oe));
        rchk("ph1 rb", ADDR_PHASE1, 8'h3C);
        wset(ADDR_CONFIG, 8'h01);
        chk("oe b0", 32'h0000_005A, 32'(port_oe));
        wset(ADDR_DIRECTION, 8'hF0);
        chk("oe dir", 32'h0000_000A, 32'(port_oe));
        rchk("dir rb", ADDR_DIRECTION, 8'hF0);
    endtask
    task automatic t_cfg_bits();
        wset(ADDR_CONFIG, 8'hC0);
        rchk("cfg c0", ADDR_CONFIG, 8'h00);
        wset(ADDR_CONFIG, 8'hFF);
        rchk("cfg ff", ADDR_CONFIG, 8'h3F);
    endtask
    task automatic t_ninth();
        for (int v = 0; v < 64; v++) begin
            c = 8'(v) & 8'hF7;
            wset(ADDR_CONFIG, c);
            chk("ninth", {31'h0000_0000, ~((c[0] & c[1]) ? c[5] : c[4])}, {31'h0000_0000, ninth_oe});
            chk("ninth out", 32'h0000_0000, 32'(ninth_out));
            rchk("cfg rb", ADDR_CONFIG, c);
        end
    endtask
    task automatic t_intensity();
        host_model_i.wr(ADDR_MASTER, 8'hA5);
        host_model_i.wr(ADDR_INTENS_0, 8'h21);
        host_model_i.wr(ADDR_INTENS_1, 8'h43);
        host_model_i.wr(ADDR_INTENS_2, 8'h65);
        host_model_i.wr(ADDR_INTENS_3, 8'h87);
        wset(ADDR_CONFIG, 8'h04);
        chk("int g1", 32'h5555_5555, intensity);
        chk("nint g1", 32'h0000_0005, 32'(ninth_int));
        wset(ADDR_CONFIG, 8'h00);
        chk("int g0", 32'h8765_4321, intensity);
        chk("nint g0", 32'h0000_000A, 32'(ninth_int));
        rchk("master rb", ADDR_MASTER, 8'hA5);
        rchk("int3 rb", ADDR_INTENS_3, 8'h87);
    endtask
    task automatic lvl(input logic [7:0] v, input logic [7:0] exp);
        level = v;
        repeat (8) @(negedge clock);
        rchk("flag", ADDR_CONFIG, exp);
        chk("irq pin", 32'(exp[7]), 32'(ninth_oe));
    endtask
    task automatic t_change();
        wset(ADDR_DIRECTION, 8'hFE);
        level = 8'hF0;
        repeat (8) @(negedge clock);
        wset(ADDR_CONFIG, 8'h08);
        lvl(8'hF0, 8'h08);
        lvl(8'hF1, 8'h08);
        lvl(8'hF5, 8'h88);
        lvl(8'hF1, 8'h08);
        lvl(8'hB1, 8'h88);
        rchk("in", ADDR_INPUT_PORTS, 8'hB1);
        rchk("clr", ADDR_CONFIG, 8'h08);
    endtask
    task automatic give_verdict();
        if (mismatches == 0 && tests_run > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        repeat (2) @(negedge clock);
        reset = 1'b0;
        t_reset();
        t_pattern();
        t_cfg_bits();
        t_ninth();
        t_intensity();
        t_change();
        give_verdict();
    end
    // Whole run needs about 520 cycles
    initial begin
        #100000;
        mismatches++;
        give_verdict();
    end
endmodule // expander_config_blink_ctrl_test
`default_nettype wire
